// ### inc/adiw_regs.svh
/*
  Register offsets, field positions and reset values of the analog-die
  interrupt and wake-up block. Assumes an APB slave with 32-bit data.
*/
`ifndef ADIW_REGS_SVH
`define ADIW_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets (printed index times four)
// ----------------------------------------------------------------
`define ADIW_IDX_MASK 5'h04
`define ADIW_IDX_FLAG 5'h05
`define ADIW_IDX_CTRL 5'h03
`define ADIW_IDX_HALL 5'h08
`define ADIW_IDX_STAT 5'h0c
`define ADIW_OFF_MASK 12'h010
`define ADIW_OFF_FLAG 12'h014
`define ADIW_OFF_CTRL 12'h00c
`define ADIW_OFF_HALL 12'h020
`define ADIW_OFF_STAT 12'h030

// ----------------------------------------------------------------
// Bit positions in mask, flag and control registers
// ----------------------------------------------------------------
`define ADIW_BIT_OC 1
`define ADIW_BIT_OV 2
`define ADIW_BIT_UV 3
`define ADIW_BIT_OT 4
`define ADIW_BIT_BUS 5
`define ADIW_BIT_SNS 6
`define ADIW_BIT_WD 7
`define ADIW_BIT_STOP 0
`define ADIW_BIT_LVR 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADIW_RST_MASK 8'h00
`define ADIW_RST_FLAG 8'h00
`define ADIW_RST_CTRL 8'h00
`define ADIW_RST_HALL 3'h0

`endif

// ### inc/adiw_pkg.sv
/*
  Types of the analog-die interrupt and wake-up block.
  Assumes the constants header is compiled alongside.
*/
package adiw_pkg;

  // Power mode of the die
  typedef enum logic [0:0] {
    ADIW_RUN = 1'b0,
    ADIW_STOP = 1'b1
  } adiw_mode_t;

  // Analog event inputs
  typedef struct packed {
    logic undervoltage_event;
    logic overvoltage_event;
    logic overtemp_event;
    logic bus_rx;
    logic [2:0] sensor_inputs;
    logic overcurrent_event;
    logic wd_wake;
    logic cyclic_check;
    logic low_voltage_reset;
  } adiw_evt_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] mask_reg;
    logic [7:0] flag_reg;
    logic [2:0] hall_en_reg;
    adiw_mode_t mode_reg;
    logic bus_prev_reg;
    logic [2:0] sns_prev_reg;
    logic irq_oe_reg;
    logic rst_oe_reg;
    logic hs_off_reg;
    logic wake_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
  } adiw_state_t;

endpackage : adiw_pkg

// ### rtl/adiw_core.sv
/*
  Interrupt and wake-up logic of the analog die: event flags, masks,
  open-drain interrupt and reset pins, high-side shut-off and wake-up.
  Assumes analog event inputs synchronous to clk and an APB master.
*/
// Local design decisions: the APB register port and the address map.
// What this block does
// - Seven interrupt sources, each with its own software-written mask bit.
// - Any reset clears all interrupt enable bits.
// - Supply under-voltage sets its flag; interrupt only when enabled.
// - In RUN, under-voltage switches off all high-side transistors and driver.
// - In STOP, under-voltage detection gives no flag or interrupt.
// - Supply over-voltage sets its flag; interrupt only when enabled.
// - In RUN, over-voltage switches off all high-side transistors and driver.
// - In STOP, over-voltage detection gives no flag or interrupt.
// - Over-temperature sets its flag; interrupt when enabled.
// - In STOP, over-temperature detection gives no flag or interrupt.
// - Bus falling edge raises interrupt when its enable is set.
// - In STOP, enabled bus falling edge wakes the whole system.
// - Enabled sensor input above threshold raises interrupt when enabled.
// - In STOP, sensor inputs checked only in cyclic checks; hit wakes.
// - Overcurrent on bridges, high-side or sensor supply raises interrupt.
// - Exactly four wake causes: bus edge, watchdog, sensor check, LOW_VOLTAGE_RESET.
// - Masked-in wake cause wakes microcontroller and main regulator.
// - Open-drain interrupt output; microcontroller uses it as input.
// - Reset pin is bidirectional open drain, shared with microcontroller.
// - Flags clear only on written one; zero keeps; reset clears.
// - Bus edge flag set by any falling edge, held until cleared.
// - In RUN, any change on an enabled sensor input sets its flag.
`timescale 1ns/100ps
`default_nettype none
`include "adiw_regs.svh"

module adiw_core
  import adiw_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic reset_n, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire adiw_evt_t evt, // Analog events
  input wire logic irq_in, // Interrupt pin level
  input wire logic rst_in, // Reset pin level
  output logic irq_out, // Interrupt pin value, always 0
  output logic irq_oe, // Interrupt pin pulled low
  output logic rst_out, // Reset pin value, always 0
  output logic rst_oe, // Reset pin pulled low
  output logic hs_off, // High-side shut-off
  output logic wake_main_regulator // Wake to main regulator
);

  adiw_state_t s_reg;
  adiw_state_t s_next;

  // ------------------------------------------------------------
  // Combinational next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic wr;
    logic ans;
    logic access;
    logic stop;
    logic bus_fall;
    logic sns_chg;
    logic sns_hi;
    logic wake_v;
    set_v = 8'h00;
    clr_v = 8'h00;
    wr = 1'b0;
    ans = 1'b0;
    access = 1'b0;
    stop = 1'b0;
    bus_fall = 1'b0;
    sns_chg = 1'b0;
    sns_hi = 1'b0;
    wake_v = 1'b0;
    s_next = s_reg;
    stop = (s_reg.mode_reg == ADIW_STOP);
    // Decode early in the access phase; a write lands as pready is seen
    access = psel && penable;
    ans = access && !s_reg.pready_reg;
    wr = access && s_reg.pready_reg && pwrite;
    // Edge and level detection on inputs
    bus_fall = s_reg.bus_prev_reg && !evt.bus_rx;
    sns_chg = |((evt.sensor_inputs ^ s_reg.sns_prev_reg) & s_reg.hall_en_reg);
    sns_hi = |(evt.sensor_inputs & s_reg.hall_en_reg) && evt.cyclic_check;
    s_next.bus_prev_reg = evt.bus_rx;
    s_next.sns_prev_reg = evt.sensor_inputs;
    // Supply and thermal detectors are gated off in STOP
    set_v[`ADIW_BIT_UV] = evt.undervoltage_event && !stop;
    set_v[`ADIW_BIT_OV] = evt.overvoltage_event && !stop;
    set_v[`ADIW_BIT_OT] = evt.overtemp_event && !stop;
    set_v[`ADIW_BIT_BUS] = bus_fall;
    set_v[`ADIW_BIT_SNS] = stop ? sns_hi : sns_chg;
    set_v[`ADIW_BIT_OC] = evt.overcurrent_event;
    set_v[`ADIW_BIT_WD] = stop && evt.wd_wake;
    // APB: one wait state, so ready and read data come from flip-flops
    s_next.pready_reg = ans;
    s_next.pslverr_reg = 1'b0;
    s_next.prdata_reg = 32'h00000000;
    if (ans || wr) begin
      case (paddr)
        `ADIW_OFF_MASK: begin
          if (wr) s_next.mask_reg = pwdata[7:0] & 8'hfe;
          s_next.prdata_reg = {24'h000000, s_reg.mask_reg};
        end
        `ADIW_OFF_FLAG: begin
          if (wr) clr_v = pwdata[7:0];
          s_next.prdata_reg = {24'h000000, s_reg.flag_reg};
        end
        `ADIW_OFF_CTRL: begin
          if (wr) s_next.mode_reg = adiw_mode_t'(pwdata[`ADIW_BIT_STOP]);
          s_next.prdata_reg = {31'h00000000, s_reg.mode_reg};
        end
        `ADIW_OFF_HALL: begin
          if (wr) s_next.hall_en_reg = pwdata[2:0];
          s_next.prdata_reg = {29'h00000000, s_reg.hall_en_reg};
        end
        `ADIW_OFF_STAT: begin
          s_next.prdata_reg = {28'h0000000, rst_in, irq_in, s_reg.hs_off_reg,
                               s_reg.wake_reg};
        end
        default: begin
          s_next.pslverr_reg = ans;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    s_next.flag_reg = ((s_reg.flag_reg & ~clr_v) | set_v) & 8'hfe;
    // Wake causes: bus edge, watchdog, sensor check, low-voltage reset
    wake_v = stop && (
      (bus_fall && s_reg.mask_reg[`ADIW_BIT_BUS]) ||
      (evt.wd_wake && s_reg.mask_reg[`ADIW_BIT_WD]) ||
      (sns_hi && s_reg.mask_reg[`ADIW_BIT_SNS]) ||
      evt.low_voltage_reset);
    s_next.wake_reg = wake_v;
    if (wake_v) s_next.mode_reg = ADIW_RUN;
    // Interrupt line low while any enabled flag stands
    s_next.irq_oe_reg = |(s_next.flag_reg & s_reg.mask_reg) || wake_v;
    // High side off while supply fault active in RUN
    s_next.hs_off_reg = !stop && (evt.undervoltage_event || evt.overvoltage_event);
    s_next.rst_oe_reg = evt.low_voltage_reset;
  end

  // ------------------------------------------------------------
  // State register; reset clears masks and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || !rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = s_reg.prdata_reg;
  assign pready = s_reg.pready_reg;
  assign pslverr = s_reg.pslverr_reg;
  assign irq_out = 1'b0;
  assign irq_oe = s_reg.irq_oe_reg;
  assign rst_out = 1'b0;
  assign rst_oe = s_reg.rst_oe_reg;
  assign hs_off = s_reg.hs_off_reg;
  assign wake_main_regulator = s_reg.wake_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence uv_seen;
    evt.undervoltage_event && s_reg.mode_reg == ADIW_RUN;
  endsequence

  chk_uv_flag_set: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    uv_seen |=> s_reg.flag_reg[`ADIW_BIT_UV]) else $error("uv flag not set");
  chk_uv_hs_off: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    uv_seen |=> hs_off) else $error("high side not off on uv");
  chk_stop_no_uv: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (s_reg.mode_reg == ADIW_STOP && !s_reg.flag_reg[`ADIW_BIT_UV]
      && !(psel && penable && pready && pwrite)) |=> !s_reg.flag_reg[`ADIW_BIT_UV])
    else $error("uv flag set in stop");
  chk_ov_hs_off: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (evt.overvoltage_event && s_reg.mode_reg == ADIW_RUN) |=> hs_off)
    else $error("high side not off on ov");
  chk_bus_flag: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    ($past(evt.bus_rx) && !evt.bus_rx) |=> s_reg.flag_reg[`ADIW_BIT_BUS])
    else $error("bus edge flag missed");
  chk_flag_hold: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (s_reg.flag_reg[`ADIW_BIT_OC] && !(psel && penable && pready && pwrite
      && paddr == `ADIW_OFF_FLAG)) |=> s_reg.flag_reg[`ADIW_BIT_OC])
    else $error("flag lost without clear");
  chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (|(s_reg.flag_reg & s_reg.mask_reg)) |-> ##[0:1] irq_oe)
    else $error("irq not driven");
  chk_wake_run: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    wake_main_regulator |-> s_reg.mode_reg == ADIW_RUN) else $error("wake left stop");
  chk_mask_reset: assert property (@(posedge clk)
    !reset_n |=> s_reg.mask_reg == `ADIW_RST_MASK) else $error("mask not cleared");
  chk_flag_reset: assert property (@(posedge clk)
    !reset_n |=> s_reg.flag_reg == `ADIW_RST_FLAG) else $error("flags not cleared");
  chk_ov_flag_set: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (evt.overvoltage_event && s_reg.mode_reg == ADIW_RUN) |=> s_reg.flag_reg[`ADIW_BIT_OV])
    else $error("ov flag not set");
  chk_stop_no_ov: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (s_reg.mode_reg == ADIW_STOP && !s_reg.flag_reg[`ADIW_BIT_OV])
      |=> !s_reg.flag_reg[`ADIW_BIT_OV])
    else $error("ov flag set in stop");
  chk_ot_flag_set: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (evt.overtemp_event && s_reg.mode_reg == ADIW_RUN) |=> s_reg.flag_reg[`ADIW_BIT_OT])
    else $error("ot flag not set");
  chk_stop_no_ot: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (s_reg.mode_reg == ADIW_STOP && !s_reg.flag_reg[`ADIW_BIT_OT])
      |=> !s_reg.flag_reg[`ADIW_BIT_OT])
    else $error("ot flag set in stop");
  chk_oc_flag_set: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    evt.overcurrent_event |=> s_reg.flag_reg[`ADIW_BIT_OC]) else $error("oc flag not set");
  chk_wake_bus: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (s_reg.mode_reg == ADIW_STOP && s_reg.mask_reg[`ADIW_BIT_BUS]
      && $past(evt.bus_rx) && !evt.bus_rx) |=> wake_main_regulator)
    else $error("bus edge did not wake");
  chk_wake_sensor: assert property (@(posedge clk) disable iff (!reset_n || !rst_in)
    (s_reg.mode_reg == ADIW_STOP && s_reg.mask_reg[`ADIW_BIT_SNS] && evt.cyclic_check
      && |(evt.sensor_inputs & s_reg.hall_en_reg)) |=> wake_main_regulator)
    else $error("sensor check did not wake");

endmodule : adiw_core
`default_nettype wire

// ### verification/adiw_mcu_model.sv
/*
  Microcontroller side of the interrupt and reset pins: resolves the
  open-drain lines with their pull-ups. Assumes enables high mean pull low.
*/
`timescale 1ns/100ps
`default_nettype none

module adiw_mcu_model (
  input wire logic irq_oe, // Die pulls interrupt low
  input wire logic rst_oe, // Die pulls reset low
  input wire logic mcu_rst_drive, // Microcontroller pulls reset low
  output logic irq_pin, // Resolved interrupt level
  output logic rst_pin // Resolved reset level
);
  // ----------------------------------------
  // Wired-AND lines, pull-up when released
  // ----------------------------------------
  assign irq_pin = !(irq_oe === 1'b1);
  assign rst_pin = !(rst_oe === 1'b1 || mcu_rst_drive);
endmodule : adiw_mcu_model

`default_nettype wire

// ### verification/tb_adiw_core.sv
/*
  Self-checking bench of the interrupt and wake-up block.
  Assumes an APB slave that may insert wait states, and flags one edge late.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adiw_regs.svh"

module tb_adiw_core
  import adiw_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, mcu_rst;
  logic irq_out, irq_oe, rst_out, rst_oe, hs_off, wake_main_regulator, irq_pin, rst_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er;
  adiw_evt_t evt;
  int mismatches = 0;
  int n_checks = 0;
  int wakes = 0;

  adiw_core uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .irq_in(irq_pin),
    .rst_in(rst_pin), .irq_out(irq_out), .irq_oe(irq_oe), .rst_out(rst_out),
    .rst_oe(rst_oe), .hs_off(hs_off), .wake_main_regulator(wake_main_regulator));
  adiw_mcu_model mcu (.irq_oe(irq_oe), .rst_oe(rst_oe), .mcu_rst_drive(mcu_rst),
    .irq_pin(irq_pin), .rst_pin(rst_pin));

  // ----------------------------------------
  // Clock and wake pulse counter
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Wake is a one-cycle pulse, so count it rather than poll it
  always @(posedge clk) if (wake_main_regulator === 1'b1) wakes++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Holds the request until pready is seen; bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    // One idle edge, so a following call never re-raises psel in this step
    @(posedge clk);
    if (i == 20) begin
      mismatches++;
      conclude();
    end
  endtask : apb

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(0, `ADIW_OFF_MASK, 0); chk(rd, 0, "mask after reset");
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 0, "flags after reset");
    chk(irq_oe, 0, "irq idle");
  endtask : t_reset
  task automatic t_regs();
    apb(1, `ADIW_OFF_MASK, 32'h000000ff); apb(0, `ADIW_OFF_MASK, 0);
    chk(rd, 32'h000000fe, "seven mask bits");
    apb(0, 12'h3fc, 0); chk(er, 1, "unmapped refused");
    apb(1, `ADIW_OFF_MASK, 0);
  endtask : t_regs
  task automatic t_uv();
    evt.undervoltage_event <= 1; cyc(3);
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 32'h08, "uv flag");
    chk(hs_off, 1, "high side off");
    chk(irq_oe, 0, "masked uv quiet");
    evt.undervoltage_event <= 0; apb(1, `ADIW_OFF_MASK, 32'h08); cyc(2);
    chk(irq_oe, 1, "enabled flag pulls irq");
    chk(irq_pin, 0, "irq line low");
    chk(hs_off, 0, "high side back");
    apb(1, `ADIW_OFF_FLAG, 0); apb(0, `ADIW_OFF_FLAG, 0);
    chk(rd, 32'h08, "zero write keeps");
    apb(1, `ADIW_OFF_FLAG, 32'h08); cyc(2);
    chk(irq_oe, 0, "irq released");
  endtask : t_uv
  task automatic t_bus();
    evt.bus_rx <= 0; cyc(3); evt.bus_rx <= 1; cyc(3);
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 32'h20, "bus edge flag held");
    apb(1, `ADIW_OFF_FLAG, 32'h20);
  endtask : t_bus
  task automatic t_stop();
    int n;
    apb(1, `ADIW_OFF_MASK, 32'h28); apb(1, `ADIW_OFF_CTRL, 32'h01);
    evt.undervoltage_event <= 1; evt.overvoltage_event <= 1; cyc(3);
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 0, "uv ov ignored in stop");
    evt.undervoltage_event <= 0; evt.overvoltage_event <= 0;
    n = wakes; evt.bus_rx <= 0; cyc(4);
    chk(wakes - n, 1, "bus edge wakes once");
    chk(irq_oe, 1, "enabled bus edge pulls irq");
    evt.bus_rx <= 1;
    apb(0, `ADIW_OFF_CTRL, 0); chk(rd, 0, "back in run");
  endtask : t_stop
  task automatic t_faults();
    evt.overcurrent_event <= 1; evt.overvoltage_event <= 1;
    evt.overtemp_event <= 1; cyc(3);
    chk(hs_off, 1, "high side off on ov");
    evt.overcurrent_event <= 0; evt.overvoltage_event <= 0;
    evt.overtemp_event <= 0; cyc(3);
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 32'h16, "oc ov ot flags held");
    apb(1, `ADIW_OFF_FLAG, 32'h16); apb(0, `ADIW_OFF_FLAG, 0);
    chk(rd, 0, "flags cleared by ones");
  endtask : t_faults
  task automatic t_sensor();
    int n;
    apb(1, `ADIW_OFF_FLAG, 32'hfe); apb(1, `ADIW_OFF_HALL, 32'h01);
    evt.sensor_inputs <= 3'h2; cyc(3);
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 0, "disabled input ignored");
    evt.sensor_inputs <= 3'h3; cyc(3);
    apb(0, `ADIW_OFF_FLAG, 0); chk(rd, 32'h40, "enabled input change");
    apb(1, `ADIW_OFF_FLAG, 32'h40); apb(1, `ADIW_OFF_MASK, 32'h40);
    apb(1, `ADIW_OFF_CTRL, 32'h01); n = wakes; cyc(3);
    chk(wakes - n, 0, "no wake between checks");
    evt.cyclic_check <= 1; cyc(1); evt.cyclic_check <= 0; cyc(3);
    chk(wakes - n, 1, "cyclic check wakes");
    evt.sensor_inputs <= 3'h0;
  endtask : t_sensor
  task automatic t_rst();
    apb(1, `ADIW_OFF_MASK, 32'h02);
    mcu_rst <= 1; cyc(2); mcu_rst <= 0; cyc(2);
    chk(rst_oe, 0, "die leaves reset line");
    chk({irq_out, rst_out}, 0, "pins only pulled low");
    apb(0, `ADIW_OFF_MASK, 0); chk(rd, 0, "shared reset clears masks");
  endtask : t_rst

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    evt = '0;
    mcu_rst = 0;
    evt.bus_rx = 1;
    cyc(16);
    reset_n <= 1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_uv();
    t_bus();
    t_faults();
    t_stop();
    t_sensor();
    t_rst();
    conclude();
  end
endmodule : tb_adiw_core

`default_nettype wire
